// File: src/page_descriptor_checker.sv
// page descriptor checker with its register file on the bus
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module page_descriptor_checker
#(
  parameter int PAGES = mmu_pkg::NUM_PAGES
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [mmu_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [mmu_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [mmu_pkg::DATA_W-1:0] hrdata,
  // reference from the processor
  input wire logic ref_valid,
  input wire logic [mmu_pkg::VA_W-1:0] ref_va,
  input wire logic ref_write,
  input wire logic ref_internal,
  input wire logic instr_done,
  // check result
  output logic res_valid,
  output logic res_allow,
  output logic [mmu_pkg::PAGE_SEL_W-1:0] res_page,
  output logic abort_not_resident,
  output logic abort_length,
  output logic abort_read_only,
  output logic trap_request,
  output logic [15:0] trap_vector
);
  import mmu_pkg::*;

  // elaboration check: one descriptor per page select value
  if (PAGES != NUM_PAGES)
  begin
    $error("page count must match the three page select bits");
  end

  desc_t base_reg [PAGES];
  desc_t desc_reg [PAGES];
  logic trap_enable;
  logic trap_pending;
  bus_state_e bus_state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [PAGE_SEL_W-1:0] sel;
  logic chk_pass;
  logic hist_write;
  logic hist_attn;
  logic bus_take;

  check_if chk ();

  access_check u_check
  (
    .chk(chk)
  );

  // decode helpers
  function automatic logic in_group(input logic [7:0] a, input logic [7:0] ofs);
    in_group = (a & GROUP_MASK) == ofs;
  endfunction

  function automatic logic [PAGE_SEL_W-1:0] page_of(input logic [7:0] a);
    page_of = a[2 +: PAGE_SEL_W];
  endfunction

  // page selection and checker inputs
  always_comb
  begin
    sel = ref_va[VA_W-1 -: PAGE_SEL_W];
    chk.desc = desc_reg[sel];
    chk.block = ref_va[BLOCK_LSB +: LEN_W];
    chk.is_write = ref_write;
  end

  // reference outcome and history events
  always_comb
  begin
    chk_pass = !(chk.abort_nr || chk.abort_len || chk.abort_ro);
    hist_write = ref_valid && !ref_internal && chk_pass && ref_write;
    hist_attn = ref_valid && !ref_internal && chk_pass && chk.trap_cond;
    bus_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  end

  // bus state: writes zero wait, reads take one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state <= bus_idle;
      hreadyout <= 1'b1;
      rd_addr <= 8'h00;
    end
    else
    begin
      case (bus_state)
        bus_idle:
        begin
          if (bus_take && !hwrite)
          begin
            bus_state <= bus_read_wait;
            hreadyout <= 1'b0;
            rd_addr <= haddr[7:0];
          end
        end
        bus_read_wait:
        begin
          bus_state <= bus_idle;
          hreadyout <= 1'b1;
        end
        default:
        begin
          bus_state <= bus_idle;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // write address capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= bus_take && hwrite;
      if (bus_take && hwrite)
        wr_addr <= haddr[7:0];
    end
  end

  // response is always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // read data, loaded in the wait state; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (bus_state == bus_read_wait)
    begin
      hrdata <= '0;
      if (rd_addr >= REG_SPAN)
        hrdata <= '0;
      else if (in_group(rd_addr, BASE_OFS))
        hrdata <= {16'h0000, base_reg[page_of(rd_addr)]};
      else if (in_group(rd_addr, DESC_OFS))
        hrdata <= {16'h0000, desc_reg[page_of(rd_addr)]};
      else if (rd_addr == CTRL_OFS)
        hrdata <= {31'h0, trap_enable};
      else if (rd_addr == STAT_OFS)
        hrdata <= {31'h0, trap_pending};
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trap_enable <= 1'b0;
    else if (wr_pend && wr_addr == CTRL_OFS)
      trap_enable <= hwdata[CTRL_TRAP_EN_BIT];
  end

  // base and descriptor storage with page history bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < PAGES; i++)
      begin
        base_reg[i] <= BASE_RESET;
        desc_reg[i] <= DESC_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < PAGES; i++)
      begin
        if (wr_pend && wr_addr < CTRL_OFS && page_of(wr_addr) == PAGE_SEL_W'(i))
        begin
          if (in_group(wr_addr, BASE_OFS))
            base_reg[i] <= hwdata[DESC_W-1:0];
          else
            desc_reg[i] <= (hwdata[DESC_W-1:0] & DESC_SW_MASK) |
              (desc_reg[i] & ~DESC_SW_MASK);
          desc_reg[i][WRITTEN_BIT] <= 1'b0;
          desc_reg[i][ATTN_BIT] <= 1'b0;
        end
        if (hist_write && sel == PAGE_SEL_W'(i))
          desc_reg[i][WRITTEN_BIT] <= 1'b1;
        if (hist_attn && sel == PAGE_SEL_W'(i))
          desc_reg[i][ATTN_BIT] <= 1'b1;
      end
    end
  end

  // registered result, one cycle after the reference
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      res_valid <= 1'b0;
      res_allow <= 1'b0;
      res_page <= '0;
      abort_not_resident <= 1'b0;
      abort_length <= 1'b0;
      abort_read_only <= 1'b0;
    end
    else
    begin
      res_valid <= ref_valid;
      res_page <= sel;
      res_allow <= ref_valid && (ref_internal || chk_pass);
      abort_not_resident <= ref_valid && !ref_internal && chk.abort_nr;
      abort_length <= ref_valid && !ref_internal && chk.abort_len;
      abort_read_only <= ref_valid && !ref_internal && chk.abort_ro;
    end
  end

  // deferred trap, taken at instruction end; a new condition wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trap_pending <= 1'b0;
      trap_request <= 1'b0;
      trap_vector <= 16'h0000;
    end
    else
    begin
      trap_vector <= TRAP_VECTOR;
      trap_request <= instr_done && trap_pending;
      if (hist_attn && trap_enable)
        trap_pending <= 1'b1;
      else if (instr_done)
        trap_pending <= 1'b0;
    end
  end

  // checks
  sequence s_trap_ref;
    hist_attn && trap_enable && !instr_done;
  endsequence

  sequence s_end_instr;
    instr_done [*1];
  endsequence

  // read accepted while the bus is idle
  sequence s_read_take;
    bus_state == bus_idle && bus_take && !hwrite;
  endsequence

  a_abort_no_allow: assert property (@(posedge hclk) disable iff (!hresetn)
    (abort_not_resident || abort_length || abort_read_only) |-> !res_allow)
    else $error("aborted reference reported as allowed");

  a_trap_deferred: assert property (@(posedge hclk) disable iff (!hresetn)
    s_trap_ref ##1 !instr_done ##1 s_end_instr |=> trap_request)
    else $error("deferred trap not requested at instruction end");

  a_no_trap_early: assert property (@(posedge hclk) disable iff (!hresetn)
    trap_request |-> $past(instr_done) && $past(trap_pending))
    else $error("trap requested before instruction end");

  a_nonres_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && (chk.desc[2:0] == 3'h0 || chk.desc[2:0] == 3'h3 ||
    chk.desc[2:0] == 3'h7) |=> abort_not_resident && !res_allow)
    else $error("non-resident or reserved key not aborted");

  a_ro_write_abort: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && ref_write &&
    (chk.desc[2:0] == 3'h1 || chk.desc[2:0] == 3'h2) |=> abort_read_only)
    else $error("write to read-only page not aborted");

  a_rw_clean: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && chk.desc[2:0] == 3'h6 && !chk.abort_len
    |-> !chk.trap_cond ##1 res_allow)
    else $error("read-write page trapped or aborted");

  a_up_length: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && !chk.desc[DIR_BIT] &&
    ref_va[12:6] > chk.desc[14:8] |=> abort_length)
    else $error("upward page length violation missed");

  a_down_length: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && chk.desc[DIR_BIT] &&
    ref_va[12:6] >= chk.desc[14:8] && chk.desc[2:0] == 3'h6 |=> !abort_length)
    else $error("downward page within length was aborted");

  a_down_short: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !ref_internal && chk.desc[DIR_BIT] &&
    ref_va[12:6] < chk.desc[14:8] |=> abort_length)
    else $error("downward page length violation missed");

  a_written_set: assert property (@(posedge hclk) disable iff (!hresetn)
    hist_write |=> desc_reg[$past(sel)][WRITTEN_BIT])
    else $error("written bit not set by a page write");

  a_attn_trap_off: assert property (@(posedge hclk) disable iff (!hresetn)
    hist_attn && !trap_enable |=> desc_reg[$past(sel)][ATTN_BIT] && !trap_pending ||
    $past(trap_pending))
    else $error("attention bit not logged with trap enable off");

  a_abort_no_hist: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && !chk_pass && !(wr_pend && wr_addr < CTRL_OFS) |=>
    $past(desc_reg[sel][ATTN_BIT:WRITTEN_BIT]) == desc_reg[$past(sel)][ATTN_BIT:WRITTEN_BIT])
    else $error("aborted reference changed the page history bits");

  a_internal_hist: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && ref_internal && !(wr_pend && wr_addr < CTRL_OFS) |=>
    $past(desc_reg[sel][ATTN_BIT:WRITTEN_BIT]) == desc_reg[$past(sel)][ATTN_BIT:WRITTEN_BIT])
    else $error("internal access changed the page history bits");

  a_internal_free: assert property (@(posedge hclk) disable iff (!hresetn)
    ref_valid && ref_internal |=>
    res_allow && !abort_not_resident && !abort_length && !abort_read_only)
    else $error("internal access was aborted");

  a_sw_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && in_group(wr_addr, BASE_OFS) && !(ref_valid && sel == page_of(wr_addr))
    |=> !desc_reg[page_of($past(wr_addr))][ATTN_BIT])
    else $error("base write did not clear attention bit");

  a_desc_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend && in_group(wr_addr, DESC_OFS) && !(ref_valid && sel == page_of(wr_addr))
    |=> !desc_reg[page_of($past(wr_addr))][WRITTEN_BIT])
    else $error("descriptor write did not clear written bit");

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_take |=> !hreadyout ##1 hreadyout)
    else $error("read data phase did not insert one wait state");
endmodule

// File: src/mmu_pkg.sv
// constants, types and register map for the page descriptor checker
// Contract
// - descriptor low three bits hold the access key deciding allow, abort or trap.
// - an aborted reference is killed at once; no read data, no memory change.
// - a trapping reference completes; its trap waits for the instruction end.
// - key 000 aborts every read and write.
// - key 001 traps after reads through 250 and aborts writes.
// - key 010 reads without trap and aborts writes.
// - keys 011 and 111 abort every access.
// - key 100 allows reads and writes, each trapping through 250.
// - key 101 allows reads and writes, only writes trap through 250.
// - key 110 allows reads and writes with no trap nor abort.
// - stores and read-modify-write cycles count as writes.
// - descriptor bit 3 picks growth: 0 upward, 1 downward.
// - bit 6 sets on a page write that is not aborted, under any key that allows writes, regardless of trap enable.
// - written and attention bits clear when software writes base or descriptor.
// - aborted references and internal register accesses set no history bits.
// - bit 7 sets on every trap condition, even with trap enable off.
// - descriptor bits 14 to 8 hold a seven-bit length in 32-word blocks.
// - upward page aborts when address bits 12 to 6 exceed the length.
// - downward page aborts when the block number is below the length.
// - top three address bits select the base and descriptor pair.
package mmu_pkg;
  localparam int DATA_W = 32;
  localparam int VA_W = 16;
  localparam int DESC_W = 16;
  localparam int PAGE_SEL_W = 3;
  localparam int NUM_PAGES = 8;
  localparam int KEY_LSB = 0;
  localparam int KEY_W = 3;
  localparam int DIR_BIT = 3;
  localparam int WRITTEN_BIT = 6;
  localparam int ATTN_BIT = 7;
  localparam int LEN_LSB = 8;
  localparam int LEN_W = 7;
  localparam int BLOCK_LSB = 6;
  localparam int CTRL_TRAP_EN_BIT = 0;

  typedef logic [DESC_W-1:0] desc_t;
  typedef logic [LEN_W-1:0] block_t;

  typedef enum logic [KEY_W-1:0] {
    key_not_resident = 3'h0,
    key_read_trap = 3'h1,
    key_read_only = 3'h2,
    key_reserved_a = 3'h3,
    key_rw_trap_all = 3'h4,
    key_rw_trap_write = 3'h5,
    key_read_write = 3'h6,
    key_reserved_b = 3'h7
  } access_key_e;

  typedef enum logic [0:0] {
    bus_idle = 1'h0,
    bus_read_wait = 1'h1
  } bus_state_e;

  // software-writable descriptor bits: length, direction, key
  localparam desc_t DESC_SW_MASK = 16'h7F0F;
  localparam desc_t DESC_RESET = 16'h0000;
  localparam desc_t BASE_RESET = 16'h0000;
  // trap vector, 250 octal
  localparam logic [15:0] TRAP_VECTOR = 16'h00A8;

  // byte offsets on the register bus
  localparam logic [7:0] BASE_OFS = 8'h00;
  localparam logic [7:0] DESC_OFS = 8'h20;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic [7:0] STAT_OFS = 8'h44;
  localparam logic [7:0] GROUP_MASK = 8'hE0;
  localparam logic [7:0] REG_SPAN = 8'h4C;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// File: src/check_if.sv
// descriptor check signals shared by the top and the checker
`timescale 1ns/10ps
interface check_if;
  import mmu_pkg::*;
  desc_t desc;
  block_t block;
  logic is_write;
  logic abort_nr;
  logic abort_len;
  logic abort_ro;
  logic trap_cond;

  modport judge (input desc, input block, input is_write,
    output abort_nr, output abort_len, output abort_ro, output trap_cond);
  modport requester (output desc, output block, output is_write,
    input abort_nr, input abort_len, input abort_ro, input trap_cond);
endinterface

// File: src/access_check.sv
// combinational key and length check of one reference
`timescale 1ns/10ps
module access_check
(
  check_if.judge chk
);
  import mmu_pkg::*;

  access_key_e key;
  block_t limit;
  logic down;

  // field split of the descriptor
  always_comb
  begin
    key = access_key_e'(chk.desc[KEY_LSB +: KEY_W]);
    limit = chk.desc[LEN_LSB +: LEN_W];
    down = chk.desc[DIR_BIT];
  end

  // key decode
  always_comb
  begin
    chk.abort_nr = 1'b0;
    chk.abort_ro = 1'b0;
    chk.trap_cond = 1'b0;
    case (key)
      key_not_resident: chk.abort_nr = 1'b1;
      key_read_trap:
      begin
        chk.abort_ro = chk.is_write;
        chk.trap_cond = !chk.is_write;
      end
      key_read_only: chk.abort_ro = chk.is_write;
      key_rw_trap_all: chk.trap_cond = 1'b1;
      key_rw_trap_write: chk.trap_cond = chk.is_write;
      key_read_write: chk.trap_cond = 1'b0;
      key_reserved_a, key_reserved_b: chk.abort_nr = 1'b1;
      default: chk.abort_nr = 1'b1;
    endcase
  end

  // length check in either direction
  always_comb
  begin
    if (down)
      chk.abort_len = chk.block < limit;
    else
      chk.abort_len = chk.block > limit;
  end
endmodule

// File: tb/cpu_ref_model.sv
// processor side model issuing references and instruction ends
`timescale 1ns/10ps
module cpu_ref_model
(
  // clock
  input wire logic hclk,
  // result from the checker
  input wire logic res_valid,
  input wire logic res_allow,
  input wire logic abort_not_resident,
  input wire logic abort_length,
  input wire logic abort_read_only,
  input wire logic trap_request,
  // reference to the checker
  output logic ref_valid,
  output logic [15:0] ref_va,
  output logic ref_write,
  output logic ref_internal,
  output logic instr_done
);
  // quiet bus at time zero
  initial
  begin
    ref_valid = 1'b0;
    ref_va = 16'h0000;
    ref_write = 1'b0;
    ref_internal = 1'b0;
    instr_done = 1'b0;
  end

  // one reference, result taken in the cycle after it
  task automatic issue(input logic [15:0] va, input logic wr, input logic internal,
    output logic [5:0] r);
    ref_valid <= 1'b1;
    ref_va <= va;
    ref_write <= wr;
    ref_internal <= internal;
    @(posedge hclk);
    // released lines carry the inverse so stale values cannot pass
    ref_valid <= 1'b0;
    ref_va <= ~va;
    ref_write <= ~wr;
    ref_internal <= ~internal;
    @(posedge hclk);
    r = {res_valid, res_allow, abort_not_resident, abort_length, abort_read_only, trap_request};
  endtask

  // end of instruction, trap request seen one cycle later
  task automatic finish_instr(output logic tr);
    instr_done <= 1'b1;
    @(posedge hclk);
    instr_done <= 1'b0;
    @(posedge hclk);
    tr = trap_request;
  endtask
endmodule

// File: tb/page_descriptor_checker_tb_top.sv
// self-checking bench for the page descriptor checker
`timescale 1ns/10ps
module page_descriptor_checker_tb_top;
  import mmu_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic ref_valid;
  logic [15:0] ref_va;
  logic ref_write;
  logic ref_internal;
  logic instr_done;
  logic res_valid;
  logic res_allow;
  logic [2:0] res_page;
  logic abort_not_resident;
  logic abort_length;
  logic abort_read_only;
  logic trap_request;
  logic [15:0] trap_vector;
  int n_errors;
  int cmp_count;

  page_descriptor_checker page_descriptor_checker_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ref_valid(ref_valid), .ref_va(ref_va), .ref_write(ref_write),
    .ref_internal(ref_internal), .instr_done(instr_done), .res_valid(res_valid),
    .res_allow(res_allow), .res_page(res_page), .abort_not_resident(abort_not_resident),
    .abort_length(abort_length), .abort_read_only(abort_read_only),
    .trap_request(trap_request), .trap_vector(trap_vector));

  cpu_ref_model cpu_ref_model_inst (.hclk(hclk), .res_valid(res_valid),
    .res_allow(res_allow), .abort_not_resident(abort_not_resident),
    .abort_length(abort_length), .abort_read_only(abort_read_only),
    .trap_request(trap_request), .ref_valid(ref_valid), .ref_va(ref_va),
    .ref_write(ref_write), .ref_internal(ref_internal), .instr_done(instr_done));

  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // compare and report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  // single word transfer, waits on hready in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    q = hrdata;
  endtask

  // reset values, unmapped place, fixed vector
  task automatic t_reset();
    logic [31:0] q;
    ahb(DESC_OFS, 1'b0, 32'h0, q);
    chk("desc reset", 32'h0, q);
    ahb(CTRL_OFS, 1'b0, 32'h0, q);
    chk("ctrl reset", 32'h0, q);
    ahb(8'h48, 1'b1, 32'hFFFFFFFF, q);
    ahb(8'h48, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("vector", 32'h00A8, {16'h0, trap_vector});
  endtask

  // every key with read and write, result and history bits
  task automatic t_keys();
    logic [31:0] q;
    logic [5:0] r;
    logic [2:0] k;
    logic nr;
    logic ro;
    logic al;
    logic tc;
    for (int i = 0; i < 16; i++)
    begin
      k = i[3:1];
      nr = (k == 3'h0) || (k == 3'h3) || (k == 3'h7);
      ro = i[0] && ((k == 3'h1) || (k == 3'h2));
      al = !(nr || ro);
      tc = al && ((k == 3'h1 && !i[0]) || k == 3'h4 || (k == 3'h5 && i[0]));
      ahb(DESC_OFS + 8'h04, 1'b1, {24'h00007F, 5'h0, k}, q);
      cpu_ref_model_inst.issue(16'h2000, i[0], 1'b0, r);
      chk("key result", {26'h0, 1'b1, al, nr, 1'b0, ro, 1'b0}, {26'h0, r});
      ahb(DESC_OFS + 8'h04, 1'b0, 32'h0, q);
      chk("key history", {17'h0, 7'h7F, tc, al && i[0], 3'h0, k}, q);
    end
  endtask

  // length limits for both growth directions
  task automatic t_length();
    logic [15:0] dsc [5] = '{16'h0506, 16'h0506, 16'h560E, 16'h560E, 16'h560E};
    logic [6:0] blk [5] = '{7'h05, 7'h06, 7'h55, 7'h56, 7'h7F};
    logic ok [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [31:0] q;
    logic [5:0] r;
    for (int i = 0; i < 5; i++)
    begin
      ahb(DESC_OFS + 8'h08, 1'b1, {16'h0, dsc[i]}, q);
      cpu_ref_model_inst.issue({3'h2, blk[i], 6'h00}, 1'b1, 1'b0, r);
      chk("length", {26'h0, 1'b1, ok[i], 1'b0, !ok[i], 2'h0}, {26'h0, r});
      ahb(DESC_OFS + 8'h08, 1'b0, 32'h0, q);
      chk("length hist", {16'h0, dsc[i] | {9'h0, ok[i], 6'h0}}, q);
    end
  endtask

  // history cleared by base write, untouched by internal access
  task automatic t_history();
    logic [31:0] q;
    logic [5:0] r;
    ahb(DESC_OFS + 8'h0C, 1'b1, 32'h0004, q);
    cpu_ref_model_inst.issue(16'h6000, 1'b1, 1'b0, r);
    ahb(DESC_OFS + 8'h0C, 1'b0, 32'h0, q);
    chk("hist set", 32'h00C4, q);
    ahb(BASE_OFS + 8'h0C, 1'b1, 32'h1234, q);
    ahb(DESC_OFS + 8'h0C, 1'b0, 32'h0, q);
    chk("hist clear", 32'h0004, q);
    cpu_ref_model_inst.issue(16'h6000, 1'b1, 1'b1, r);
    chk("internal", {26'h0, 6'h30}, {26'h0, r});
    ahb(DESC_OFS + 8'h0C, 1'b0, 32'h0, q);
    chk("internal hist", 32'h0004, q);
  endtask

  // trap held to instruction end, abort raises none
  task automatic t_trap();
    logic [31:0] q;
    logic [5:0] r;
    logic t;
    ahb(CTRL_OFS, 1'b1, 32'h1, q);
    ahb(DESC_OFS + 8'h10, 1'b1, 32'h7F05, q);
    cpu_ref_model_inst.issue(16'h8000, 1'b0, 1'b0, r);
    cpu_ref_model_inst.finish_instr(t);
    chk("read no trap", 32'h0, {31'h0, t});
    cpu_ref_model_inst.issue(16'h8000, 1'b1, 1'b0, r);
    chk("trap deferred", {26'h0, 6'h30}, {26'h0, r});
    ahb(STAT_OFS, 1'b0, 32'h0, q);
    chk("pending", 32'h1, q);
    cpu_ref_model_inst.finish_instr(t);
    chk("trap taken", 32'h1, {31'h0, t});
    ahb(DESC_OFS + 8'h10, 1'b1, 32'h7F04, q);
    cpu_ref_model_inst.issue(16'h8000, 1'b0, 1'b0, r);
    cpu_ref_model_inst.finish_instr(t);
    chk("read trap", 32'h1, {31'h0, t});
    ahb(DESC_OFS + 8'h10, 1'b1, 32'h7F02, q);
    cpu_ref_model_inst.issue(16'h8000, 1'b1, 1'b0, r);
    chk("abort write", {26'h0, 6'h22}, {26'h0, r});
    cpu_ref_model_inst.finish_instr(t);
    chk("no trap", 32'h0, {31'h0, t});
    ahb(CTRL_OFS, 1'b1, 32'h0, q);
  endtask

  // top address bits pick the descriptor
  task automatic t_pages();
    logic [31:0] q;
    logic [5:0] r;
    ahb(DESC_OFS + 8'h1C, 1'b1, 32'h7F06, q);
    cpu_ref_model_inst.issue(16'hC000, 1'b0, 1'b0, r);
    chk("page 6", {26'h0, 6'h28}, {26'h0, r});
    chk("page 6 no", 32'h6, {29'h0, res_page});
    cpu_ref_model_inst.issue(16'hC000, 1'b0, 1'b1, r);
    chk("internal nr", {26'h0, 6'h30}, {26'h0, r});
    cpu_ref_model_inst.issue(16'hE000, 1'b1, 1'b0, r);
    chk("page 7", {26'h0, 6'h30}, {26'h0, r});
    chk("page 7 no", 32'h7, {29'h0, res_page});
  endtask

  // main sequence
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_keys();
    t_length();
    t_history();
    t_trap();
    t_pages();
    stop_test();
  end

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    stop_test();
  end
endmodule
